/* File: tai_cfg.svh */
// Purpose: constants for the thermal alarm and interrupt block
// Assumes: byte wide registers, pointer based access over the serial pins
// Notes:   definitions only
`ifndef TAI_CFG_SVH
`define TAI_CFG_SVH

// register pointers
`define TAI_PTR_STAT1     8'h02
`define TAI_PTR_CFG_RD    8'h03
`define TAI_PTR_CFG_WR    8'h09
`define TAI_PTR_ONESHOT   8'h0f
`define TAI_PTR_CONSEC    8'h22
`define TAI_PTR_STAT2     8'h23
`define TAI_PTR_HIGH      8'h40
`define TAI_PTR_LOW       8'h43
`define TAI_PTR_TRIP      8'h46
`define TAI_PTR_HYST      8'h49
`define TAI_PTR_VAL       8'h50

// config one and consecutive register fields
`define TAI_CFG_MASK_ALL  7
`define TAI_CFG_STANDBY   6
`define TAI_CFG_PIN_TRIP2 5
`define TAI_CFG_MASK_R1   1
`define TAI_CFG_MASK_R2   0
`define TAI_CONSEC_MASK_LOC 5

// status fields
`define TAI_ST1_LOC_HIGH  6
`define TAI_ST1_LOC_LOW   5
`define TAI_ST1_R1_HIGH   4
`define TAI_ST1_R1_LOW    3
`define TAI_ST_OPEN       2
`define TAI_ST2_R2_HIGH   4
`define TAI_ST2_R2_LOW    3

// reset values and bus constants
`define TAI_TRIP_RST      8'h55
`define TAI_HYST_RST      8'h0a
`define TAI_HIGH_RST      8'h46
`define TAI_LOW_RST       8'hff
`define TAI_ARA           7'h0c
`define TAI_BITS_PER_BYTE 4'h8
`define TAI_CH_LOC        2'h0
`define TAI_CH_R1         2'h1
`define TAI_CH_R2         2'h2

`endif

/* File: tai_pkg.sv */
// Purpose: types for the thermal alarm and interrupt block
// Assumes: constants live in tai_cfg.svh
// Notes:   state enums only
package tai_pkg;
    typedef enum logic [2:0] {
        TAI_BUS_IDLE, TAI_BUS_ADDR, TAI_BUS_ACK,
        TAI_BUS_RX, TAI_BUS_TX, TAI_BUS_TXACK
    } tai_bus_st_t;
    typedef enum logic {TAI_SEQ_IDLE, TAI_SEQ_CONV} tai_seq_st_t;
endpackage : tai_pkg

/* File: tai_thermal_alarm.sv */
// Purpose: alarm, trip and standby logic with its serial register port
// Assumes: converter and comparators sit outside; clock is 25 MHz
// Notes:   serial pins and comparator pins are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "tai_cfg.svh"

// Notes on behaviour
// - consecutive register bit 5 masks local alarms; resets to 0.
// - config bit 1 masks remote-1 alarms; resets to 0.
// - config bit 0 masks remote-2 alarms; resets to 0.
// - config bit 7 masks limit alarms from every channel, not open flags; resets to 0.
// - config read at pointer 0x03, written at pointer 0x09.
// - config bit 6 sets standby, aborting a conversion without storing unless a one-shot round is running.
// - serial register port keeps working in standby.
// - any one-shot write runs one conversion round then standby resumes.
// - limit writes in standby are checked at once against stored values.
// - open comparator sampled at conversion start sets status one bit 2.
// - remote-2 open fault at conversion start sets status two bit 2.
// - open flags drive the alarm low in alarm pin mode.
// - a remote value is not updated while its diode is open.
// - alarm when value above high limit or at/above low limit, masked.
// - alarm released after alert response, condition gone, status cleared.
// - fail-safe trip releases at trip limit minus hysteresis.
// - trip limits reset to 85 degrees, hysteresis to 10; writable.
// - shared pin acts as alarm or as second trip output.
// - second trip uses high limits, no masks, same hysteresis release.
// - alert response read returns own address while alarm is low.
module tai_thermal_alarm
    import tai_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h18
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe,
    output var  logic       alarm_o,
    output var  logic       alarm_oe,
    output var  logic       failsafe_trip_n,
    input  wire logic       open_cmp1,
    input  wire logic       open_cmp2,
    output var  logic       conv_req,
    output var  logic [1:0] conv_chan,
    input  wire logic       conv_done,
    input  wire logic [7:0] conv_value
);

    // limit index within a block of three pointers
    function automatic logic in_blk(input logic [7:0] p,
                                    input logic [7:0] base);
        logic [7:0] d;
        d = p - base;
        in_blk = (d < 8'h03);
    endfunction : in_blk

    // release point of a trip, saturating at zero
    function automatic logic [7:0] floor_of(input logic [7:0] lim,
                                            input logic [7:0] hy);
        floor_of = (lim > hy) ? lim - hy : 8'h00;
    endfunction : floor_of

    logic [2:0]  scl_s_r;
    logic [2:0]  sda_s_r;
    logic [1:0]  opn1_s_r;
    logic [1:0]  opn2_s_r;
    tai_bus_st_t bus_st_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  sh_r;
    logic [7:0]  tx_r;
    logic [7:0]  ptr_r;
    logic        rw_r;
    logic        first_r;
    logic        ara_r;
    logic        wr_stb_r;
    logic        ara_done_r;
    logic        rd_s1_r;
    logic        rd_s2_r;
    logic        oneshot_stb_r;
    logic [7:0]  cfg_r;
    logic [7:0]  consec_r;
    logic [7:0]  hyst_r;
    logic [7:0]  hi_r  [3];
    logic [7:0]  lo_r  [3];
    logic [7:0]  tr_r  [3];
    logic [7:0]  val_r [3];
    logic [7:0]  stat1_r;
    logic [7:0]  stat2_r;
    tai_seq_st_t seq_st_r;
    logic        oneshot_r;
    logic [2:0]  open_now_r;
    logic [2:0]  trip_on_r;
    logic [2:0]  trip2_on_r;
    logic        alert_r;
    logic [7:0]  rd_byte;
    logic [7:0]  set1;
    logic [7:0]  set2;
    logic [2:0]  hi_c;
    logic [2:0]  lo_c;
    logic [2:0]  ch_mask;
    logic        alarm_pend;
    logic        run_ok;
    logic        conv_begin;
    logic        scl;
    logic        sda;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;

    // two flop synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_r  <= 3'h7;
            sda_s_r  <= 3'h7;
            opn1_s_r <= 2'h0;
            opn2_s_r <= 2'h0;
        end else begin
            scl_s_r  <= {scl_s_r[1:0], scl_i};
            sda_s_r  <= {sda_s_r[1:0], sda_i};
            opn1_s_r <= {opn1_s_r[0], open_cmp1};
            opn2_s_r <= {opn2_s_r[0], open_cmp2};
        end
    end

    // line events from stages one and two
    assign scl       = scl_s_r[1];
    assign sda       = sda_s_r[1];
    assign scl_rise  = scl & ~scl_s_r[2];
    assign scl_fall  = ~scl & scl_s_r[2];
    assign bus_start = scl & scl_s_r[2] & ~sda & sda_s_r[2];
    assign bus_stop  = scl & scl_s_r[2] & sda & ~sda_s_r[2];

    // read data selected by the pointer
    always_comb begin
        rd_byte = 8'h00;
        if (ptr_r == `TAI_PTR_STAT1)
            rd_byte = stat1_r;
        else if (ptr_r == `TAI_PTR_STAT2)
            rd_byte = stat2_r;
        else if (ptr_r == `TAI_PTR_CFG_RD)
            rd_byte = cfg_r;
        else if (ptr_r == `TAI_PTR_CONSEC)
            rd_byte = consec_r;
        else if (ptr_r == `TAI_PTR_HYST)
            rd_byte = hyst_r;
        else if (in_blk(ptr_r, `TAI_PTR_HIGH))
            rd_byte = hi_r[2'(ptr_r - `TAI_PTR_HIGH)];
        else if (in_blk(ptr_r, `TAI_PTR_LOW))
            rd_byte = lo_r[2'(ptr_r - `TAI_PTR_LOW)];
        else if (in_blk(ptr_r, `TAI_PTR_TRIP))
            rd_byte = tr_r[2'(ptr_r - `TAI_PTR_TRIP)];
        else if (in_blk(ptr_r, `TAI_PTR_VAL))
            rd_byte = val_r[2'(ptr_r - `TAI_PTR_VAL)];
    end

    // serial slave, independent of standby
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_st_r   <= TAI_BUS_IDLE;
            bit_cnt_r  <= 4'h0;
            sh_r       <= 8'h00;
            tx_r       <= 8'h00;
            ptr_r      <= 8'h00;
            rw_r       <= 1'b0;
            first_r    <= 1'b0;
            ara_r      <= 1'b0;
            sda_oe     <= 1'b0;
            wr_stb_r   <= 1'b0;
            ara_done_r <= 1'b0;
            rd_s1_r    <= 1'b0;
            rd_s2_r    <= 1'b0;
        end else begin
            wr_stb_r   <= 1'b0;
            ara_done_r <= 1'b0;
            rd_s1_r    <= 1'b0;
            rd_s2_r    <= 1'b0;
            if (bus_start) begin
                bus_st_r  <= TAI_BUS_ADDR;
                bit_cnt_r <= 4'h0;
                first_r   <= 1'b1;
                ara_r     <= 1'b0;
                sda_oe    <= 1'b0;
            end else if (bus_stop) begin
                bus_st_r <= TAI_BUS_IDLE;
                sda_oe   <= 1'b0;
            end else begin
                unique case (bus_st_r)
                    TAI_BUS_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    TAI_BUS_ADDR, TAI_BUS_RX: begin
                        if (scl_rise) begin
                            sh_r      <= {sh_r[6:0], sda};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall &&
                                     bit_cnt_r == `TAI_BITS_PER_BYTE) begin
                            bus_st_r <= TAI_BUS_ACK;
                            sda_oe   <= 1'b1;
                            if (bus_st_r == TAI_BUS_ADDR) begin
                                rw_r <= sh_r[0];
                                tx_r <= rd_byte;
                                if (sh_r[7:1] == DEV_ADDR) begin
                                    rd_s1_r <= sh_r[0] &&
                                        ptr_r == `TAI_PTR_STAT1;
                                    rd_s2_r <= sh_r[0] &&
                                        ptr_r == `TAI_PTR_STAT2;
                                end else if (sh_r[7:1] == `TAI_ARA &&
                                             sh_r[0] && alert_r) begin
                                    ara_r <= 1'b1;
                                    tx_r  <= {DEV_ADDR, 1'b1};
                                end else begin
                                    bus_st_r <= TAI_BUS_IDLE;
                                    sda_oe   <= 1'b0;
                                end
                            end else if (first_r) begin
                                ptr_r   <= sh_r;
                                first_r <= 1'b0;
                            end else begin
                                wr_stb_r <= 1'b1;
                            end
                        end
                    end
                    TAI_BUS_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_r <= 4'h0;
                            if (rw_r) begin
                                bus_st_r  <= TAI_BUS_TX;
                                sda_oe    <= ~tx_r[7];
                                tx_r      <= {tx_r[6:0], 1'b0};
                                bit_cnt_r <= 4'h1;
                            end else begin
                                bus_st_r <= TAI_BUS_RX;
                                sda_oe   <= 1'b0;
                            end
                        end
                    end
                    TAI_BUS_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == `TAI_BITS_PER_BYTE) begin
                                sda_oe   <= 1'b0;
                                bus_st_r <= TAI_BUS_TXACK;
                            end else begin
                                sda_oe    <= ~tx_r[7];
                                tx_r      <= {tx_r[6:0], 1'b0};
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    TAI_BUS_TXACK: begin
                        if (scl_rise) begin
                            ara_done_r <= ara_r;
                            ara_r      <= 1'b0;
                            tx_r       <= rd_byte;
                            bus_st_r   <= sda ? TAI_BUS_IDLE : TAI_BUS_ACK;
                        end
                    end
                endcase
            end
        end
    end

    // register writes through the pointer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r         <= 8'h00;
            consec_r      <= 8'h00;
            hyst_r        <= `TAI_HYST_RST;
            oneshot_stb_r <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                hi_r[i] <= `TAI_HIGH_RST;
                lo_r[i] <= `TAI_LOW_RST;
                tr_r[i] <= `TAI_TRIP_RST;
            end
        end else begin
            oneshot_stb_r <= wr_stb_r && ptr_r == `TAI_PTR_ONESHOT;
            if (wr_stb_r) begin
                if (ptr_r == `TAI_PTR_CFG_WR)
                    cfg_r <= sh_r;
                if (ptr_r == `TAI_PTR_CONSEC)
                    consec_r <= sh_r;
                if (ptr_r == `TAI_PTR_HYST)
                    hyst_r <= sh_r;
                if (in_blk(ptr_r, `TAI_PTR_HIGH))
                    hi_r[2'(ptr_r - `TAI_PTR_HIGH)] <= sh_r;
                if (in_blk(ptr_r, `TAI_PTR_LOW))
                    lo_r[2'(ptr_r - `TAI_PTR_LOW)] <= sh_r;
                if (in_blk(ptr_r, `TAI_PTR_TRIP))
                    tr_r[2'(ptr_r - `TAI_PTR_TRIP)] <= sh_r;
            end
        end
    end

    // conversion sequencer: local, remote 1, remote 2
    assign run_ok     = ~cfg_r[`TAI_CFG_STANDBY] | oneshot_r;
    assign conv_begin = (seq_st_r == TAI_SEQ_IDLE) && run_ok;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seq_st_r   <= TAI_SEQ_IDLE;
            conv_req   <= 1'b0;
            conv_chan  <= `TAI_CH_LOC;
            oneshot_r  <= 1'b0;
            open_now_r <= 3'h0;
            for (int i = 0; i < 3; i++)
                val_r[i] <= 8'h00;
        end else begin
            unique case (seq_st_r)
                TAI_SEQ_IDLE: begin
                    if (run_ok) begin
                        conv_req <= 1'b1;
                        seq_st_r <= TAI_SEQ_CONV;
                        open_now_r[1] <= (conv_chan == `TAI_CH_R1) ?
                            opn1_s_r[1] : open_now_r[1];
                        open_now_r[2] <= (conv_chan == `TAI_CH_R2) ?
                            opn2_s_r[1] : open_now_r[2];
                    end
                end
                TAI_SEQ_CONV: begin
                    if (!run_ok) begin
                        conv_req <= 1'b0;
                        seq_st_r <= TAI_SEQ_IDLE;
                    end else if (conv_done) begin
                        conv_req <= 1'b0;
                        seq_st_r <= TAI_SEQ_IDLE;
                        if (!open_now_r[conv_chan])
                            val_r[conv_chan] <= conv_value;
                        conv_chan <= (conv_chan == `TAI_CH_R2) ?
                            `TAI_CH_LOC : conv_chan + 2'h1;
                    end
                end
            endcase
            // one round ends after remote 2; a new write wins
            if (oneshot_stb_r)
                oneshot_r <= 1'b1;
            else if (seq_st_r == TAI_SEQ_CONV && conv_done &&
                     conv_chan == `TAI_CH_R2)
                oneshot_r <= 1'b0;
        end
    end

    // limit compare, live on stored values and limits
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            hi_c[i] = val_r[i] > hi_r[i];
            lo_c[i] = val_r[i] >= lo_r[i];
        end
        ch_mask[0] = consec_r[`TAI_CONSEC_MASK_LOC];
        ch_mask[1] = cfg_r[`TAI_CFG_MASK_R1];
        ch_mask[2] = cfg_r[`TAI_CFG_MASK_R2];
        set1 = 8'h00;
        set2 = 8'h00;
        set1[`TAI_ST1_LOC_HIGH] = hi_c[0];
        set1[`TAI_ST1_LOC_LOW]  = lo_c[0];
        set1[`TAI_ST1_R1_HIGH]  = hi_c[1];
        set1[`TAI_ST1_R1_LOW]   = lo_c[1];
        set1[`TAI_ST_OPEN] = conv_begin && conv_chan == `TAI_CH_R1 &&
                             opn1_s_r[1];
        set2[`TAI_ST2_R2_HIGH]  = hi_c[2];
        set2[`TAI_ST2_R2_LOW]   = lo_c[2];
        set2[`TAI_ST_OPEN] = conv_begin && conv_chan == `TAI_CH_R2 &&
                             opn2_s_r[1];
        alarm_pend = 1'b0;
        for (int i = 0; i < 3; i++)
            alarm_pend = alarm_pend | ((hi_c[i] | lo_c[i]) & ~ch_mask[i]
                         & ~cfg_r[`TAI_CFG_MASK_ALL]);
        alarm_pend = alarm_pend
            | (stat1_r[`TAI_ST1_LOC_HIGH] | stat1_r[`TAI_ST1_LOC_LOW])
              & ~ch_mask[0] & ~cfg_r[`TAI_CFG_MASK_ALL]
            | (stat1_r[`TAI_ST1_R1_HIGH] | stat1_r[`TAI_ST1_R1_LOW])
              & ~ch_mask[1] & ~cfg_r[`TAI_CFG_MASK_ALL]
            | (stat2_r[`TAI_ST2_R2_HIGH] | stat2_r[`TAI_ST2_R2_LOW])
              & ~ch_mask[2] & ~cfg_r[`TAI_CFG_MASK_ALL]
            | stat1_r[`TAI_ST_OPEN] | stat2_r[`TAI_ST_OPEN];
    end

    // sticky status, cleared by reading it; a new event wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat1_r <= 8'h00;
            stat2_r <= 8'h00;
        end else begin
            stat1_r <= (rd_s1_r ? 8'h00 : stat1_r) | set1;
            stat2_r <= (rd_s2_r ? 8'h00 : stat2_r) | set2;
        end
    end

    // alarm latch, released by a served alert response when clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            alert_r <= 1'b0;
        else if (alarm_pend)
            alert_r <= 1'b1;
        else if (ara_done_r)
            alert_r <= 1'b0;
    end

    // trip comparators with hysteresis, never masked
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trip_on_r  <= 3'h0;
            trip2_on_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (val_r[i] > tr_r[i])
                    trip_on_r[i] <= 1'b1;
                else if (val_r[i] <= floor_of(tr_r[i], hyst_r))
                    trip_on_r[i] <= 1'b0;
                if (val_r[i] > hi_r[i])
                    trip2_on_r[i] <= 1'b1;
                else if (val_r[i] <= floor_of(hi_r[i], hyst_r))
                    trip2_on_r[i] <= 1'b0;
            end
        end
    end

    // pin drivers; open drain pins only ever pull low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            failsafe_trip_n <= 1'b1;
            alarm_oe        <= 1'b0;
            alarm_o         <= 1'b0;
            sda_o           <= 1'b0;
        end else begin
            failsafe_trip_n <= ~|trip_on_r;
            alarm_oe <= cfg_r[`TAI_CFG_PIN_TRIP2] ?
                        |trip2_on_r : alert_r;
            alarm_o  <= 1'b0;
            sda_o    <= 1'b0;
        end
    end

endmodule : tai_thermal_alarm
`default_nettype wire

/* File: tai_chk.sv */
// Purpose: port checks for the thermal alarm block
// Assumes: serial clock far slower than the system clock
// Notes:   attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module tai_chk (
    input wire logic       clock, rst_n, scl_i, sda_i, sda_o, sda_oe,
    input wire logic       alarm_o, alarm_oe, failsafe_trip_n,
    input wire logic       open_cmp1, open_cmp2, conv_req, conv_done,
    input wire logic [1:0] conv_chan,
    input wire logic [7:0] conv_value
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);
    // open-drain pins only ever pull low
    sda_low_a: assert property (!sda_o) else $error("sda drive high");
    alarm_low_a: assert property (!alarm_o)
        else $error("alarm drive high");
    // converter handshake
    conv_stop_a: assert property (conv_req && conv_done |=> !conv_req)
        else $error("request held after result");
    chan_hold_a: assert property (conv_req && $past(conv_req)
        |-> $stable(conv_chan)) else $error("channel moved mid request");
    chan_range_a: assert property (conv_chan != 2'h3)
        else $error("channel out of range");
    conv_run_a: assert property ($rose(rst_n) |-> ##[0:3] conv_req)
        else $error("no conversion after reset");
    // serial data only moves while the serial clock is low
    ack_hold_a: assert property (scl_i && $past(scl_i)
        |-> $stable(sda_oe)) else $error("data moved with clock high");
    ack_rise_a: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("data pulled with clock high");
    // alarm release only inside a serviced bit
    alarm_free_a: assert property ($fell(alarm_oe)
        |-> scl_i && $past(scl_i, 2)) else $error("alarm freed off bus");
    c_alarm: cover property ($rose(alarm_oe));
    c_trip: cover property ($fell(failsafe_trip_n));
    c_ack: cover property ($rose(sda_oe));
endmodule : tai_chk
bind tai_thermal_alarm tai_chk u_chk (.*);
`default_nettype wire

/* File: tai_host_model.sv */
// Purpose: serial host that reads, writes and services the alarm
// Assumes: quarter bit of 6 system clocks
// Notes:   data line has a pull-up; either party pulls it low
`timescale 1ns/1ps
`default_nettype none
module tai_host_model (
    input  wire logic       clock,
    input  wire logic       sda_oe,
    output var  logic       scl,
    output wire logic       sda,
    output var  logic [7:0] rd_data,
    output var  logic       rd_done
);
    logic       drv_low;
    logic [8:0] r;
    // wired line: high unless someone pulls it
    assign sda = !(drv_low || sda_oe);
    initial begin
        scl = 1'b1;
        drv_low = 1'b0;
        rd_done = 1'b0;
        rd_data = 8'h00;
    end
    task automatic q;
        repeat (6) @(posedge clock);
        #1;
    endtask : q
    task automatic start;
        drv_low = 1'b0;
        scl = 1'b1;
        q;
        drv_low = 1'b1;
        q;
        scl = 1'b0;
        q;
    endtask : start
    task automatic stop;
        drv_low = 1'b1;
        q;
        scl = 1'b1;
        q;
        drv_low = 1'b0;
        q;
    endtask : stop
    // eight bits and acknowledge, msb first, sampled with clock high
    task automatic bits(input logic [8:0] d);
        for (int i = 8; i >= 0; i--) begin
            drv_low = !d[i];
            q;
            scl = 1'b1;
            q;
            r[i] = sda;
            q;
            scl = 1'b0;
            q;
        end
    endtask : bits
    // address byte, then n bytes out, or one byte in ended by nack
    task automatic xact(input logic [7:0] a, input logic [15:0] w,
                        input int n);
        start;
        bits({a, 1'b1});
        for (int k = 0; k < n; k++) bits({w[15-8*k -: 8], 1'b1});
        if (a[0]) begin
            bits(9'h1ff);
            rd_data = r[8:1];
            rd_done = 1'b1;
        end
        stop;
        rd_done = 1'b0;
    endtask : xact
endmodule : tai_host_model
`default_nettype wire

/* File: tai_thermal_alarm_tb_top.sv */
// Purpose: self-checking bench for the thermal alarm block
// Assumes: host model on the pins, converter modelled here
// Notes:   read data is scored against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tai_thermal_alarm_tb_top;
    localparam logic [6:0] DEV = 7'h18;
    logic        clock, rst_n, scl, sda, sda_o, sda_oe, alarm_o, alarm_oe;
    logic        trip_n, open1, open2, conv_req, rd_done;
    logic        conv_done = 1'b0;
    logic [1:0]  conv_chan;
    logic [2:0]  cnt = 3'h0;
    logic [7:0]  conv_value = 8'h00;
    logic [7:0]  rd_data, temp [3], expq [$];
    logic [31:0] seed;
    logic [39:0] mk [4] = '{40'h2220024000, 40'h0902021001,
                            40'h0901231002, 40'h0980021001};
    int          n_fail, samples_checked, cyc;
    tai_thermal_alarm #(.DEV_ADDR(DEV)) u_dut (
        .clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .alarm_o(alarm_o),
        .alarm_oe(alarm_oe), .failsafe_trip_n(trip_n),
        .open_cmp1(open1), .open_cmp2(open2), .conv_req(conv_req),
        .conv_chan(conv_chan), .conv_done(conv_done),
        .conv_value(conv_value));
    tai_host_model u_host (.clock(clock), .sda_oe(sda_oe), .scl(scl),
        .sda(sda), .rd_data(rd_data), .rd_done(rd_done));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // xorshift step for the random stimulus
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction : xs
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        u_host.xact({DEV, 1'b0}, {p, d}, 2);
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        u_host.xact({DEV, 1'b0}, {p, 8'h00}, 1);
        expq.push_back(e);
        u_host.xact({DEV, 1'b1}, 16'h0000, 0);
    endtask : rd
    // alert response read: device answers its own address
    task automatic ara;
        expq.push_back({DEV, 1'b1});
        u_host.xact(8'h19, 16'h0000, 0);
    endtask : ara
    task automatic settle;
        repeat (60) @(posedge clock);
        #1;
    endtask : settle
    // converter: answers each request four cycles on
    always @(posedge clock) begin
        #1;
        conv_done = conv_req && cnt == 3'h3;
        cnt = (conv_req && !conv_done) ? cnt + 3'h1 : 3'h0;
        conv_value = temp[conv_chan];
    end
    // scoreboard: each finished read takes the oldest note
    always @(posedge rd_done) chk(rd_data, expq.pop_front());
    // watchdog on clock cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            results;
        end
    end
    initial begin
        rst_n = 1'b0;
        open1 = 1'b0;
        open2 = 1'b0;
        temp = '{8'h1e, 8'h1e, 8'h1e};
        seed = xs(32'hbe8c399c);
        repeat (20) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        rd(8'h03, 8'h00);
        rd(8'h46, 8'h55);
        rd(8'h49, 8'h0a);
        temp[0] = 8'h14 + {3'h0, seed[4:0]};
        rd(8'h50, temp[0]);
        // each mask hides its channel while the status still shows it
        for (int i = 0; i < 4; i++) begin
            wr(mk[i][39:32], mk[i][31:24]);
            temp[mk[i][1:0]] = 8'h50;
            rd(mk[i][23:16], mk[i][15:8]);
            chk(8'(alarm_oe), 8'h00);
            temp[mk[i][1:0]] = 8'h1e;
            rd(mk[i][23:16], mk[i][15:8]);
            wr(mk[i][39:32], 8'h00);
        end
        temp[0] = 8'h50;
        rd(8'h02, 8'h40);
        chk(8'(alarm_oe), 8'h01);
        ara;
        chk(8'(alarm_oe), 8'h01);
        temp[0] = 8'h1e;
        ara;
        chk(8'(alarm_oe), 8'h01);
        rd(8'h02, 8'h40);
        ara;
        chk(8'(alarm_oe), 8'h00);
        wr(8'h09, 8'h80);
        temp[2] = 8'h56;
        settle;
        chk(8'(trip_n), 8'h00);
        temp[2] = 8'h4c;
        settle;
        chk(8'(trip_n), 8'h00);
        temp[2] = 8'h4b;
        settle;
        chk(8'(trip_n), 8'h01);
        temp[2] = 8'h1e;
        rd(8'h23, 8'h10);
        wr(8'h09, 8'h00);
        open1 = 1'b1;
        open2 = 1'b1;
        settle;
        temp[1] = 8'h2d;
        rd(8'h51, 8'h1e);
        chk(8'(alarm_oe), 8'h01);
        rd(8'h02, 8'h04);
        rd(8'h23, 8'h04);
        open1 = 1'b0;
        open2 = 1'b0;
        temp[1] = 8'h1e;
        rd(8'h02, 8'h04);
        rd(8'h23, 8'h04);
        ara;
        chk(8'(alarm_oe), 8'h00);
        wr(8'h09, 8'h40);
        temp[2] = 8'h32;
        settle;
        chk(8'(conv_req), 8'h00);
        rd(8'h52, 8'h1e);
        seed = xs(seed);
        wr(8'h0f, seed[15:8]);
        rd(8'h52, 8'h32);
        chk(8'(conv_req), 8'h00);
        wr(8'h42, 8'h28);
        chk(8'(alarm_oe), 8'h01);
        // shared pin as second trip: mask and latch ignored
        wr(8'h09, 8'h21);
        temp[2] = 8'h1f;
        settle;
        chk(8'(alarm_oe), 8'h01);
        temp[2] = 8'h1e;
        settle;
        chk(8'(alarm_oe), 8'h00);
        // low limit alarms at equal value
        wr(8'h43, 8'h1e);
        rd(8'h02, 8'h20);
        results;
    end
endmodule : tai_thermal_alarm_tb_top
`default_nettype wire
